/* bench/adc_conv_asserts.sv */
// Timing checks on the pins between converter and host
`timescale 1ns/1ps
module adc_conv_asserts (
    input wire logic       clock,
    input wire logic       sys_rst,
    input wire logic       convert_start_first_group,
    input wire logic       convert_start_second_group,
    input wire logic       adc_reset,
    input wire logic [2:0] oversample_ratio_select,
    input wire logic       busy,
    input wire logic       chip_select_n
);
    // Slot 7 repeats slot 6 so an unused code cannot index past the end
    localparam int LO [8] = '{138, 315, 642, 1320, 2640, 5320, 10280, 10280};
    localparam int HI [8] = '{166, 364, 752, 1560, 3120, 6320, 12600, 12600};
    typedef struct packed {
        logic [15:0] busy_len;
        logic [2:0]  ratio;
        logic [7:0]  since;
        logic        cnv;
    } watch_t;
    watch_t watch_ff;
    watch_t nxt_watch;
    always_comb begin
        nxt_watch = watch_ff;
        nxt_watch.cnv = convert_start_first_group;
        nxt_watch.busy_len = busy ? watch_ff.busy_len + 16'h0001 : 16'h0000;
        if (busy && watch_ff.busy_len == 16'h0000) begin
            nxt_watch.ratio = oversample_ratio_select;
        end
        if (convert_start_first_group && !watch_ff.cnv) begin
            nxt_watch.since = 8'h00;
        end else if (watch_ff.since != 8'hff) begin
            nxt_watch.since = watch_ff.since + 8'h01;
        end
    end
    // Spacing starts saturated so the first start after reset is legal
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            watch_ff <= '{busy_len: 16'h0000, ratio: 3'h0, since: 8'hff, cnv: 1'b0};
        end else begin
            watch_ff <= nxt_watch;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    sequence start_edge;
        $rose(convert_start_first_group) && !busy && !adc_reset;
    endsequence
    AST_BUSY_RISE: assert property (start_edge |-> ##1 busy)
        else $error("busy did not follow a start edge");
    AST_CONV_MIN: assert property ($fell(busy) |-> watch_ff.busy_len >= LO[watch_ff.ratio])
        else $error("conversion too short");
    AST_CONV_MAX: assert property ($fell(busy) |-> watch_ff.busy_len <= HI[watch_ff.ratio])
        else $error("conversion too long");
    AST_CYCLE: assert property ($rose(convert_start_first_group) |-> watch_ff.since >= 8'd199)
        else $error("starts closer than the cycle period");
    AST_SELECT_AFTER_BUSY: assert property (!chip_select_n |-> !busy && !$rose(busy))
        else $error("select low while busy");
    AST_RESET_WIDTH: assert property ($fell(adc_reset) |-> $past(adc_reset, 2))
        else $error("reset pulse too short");
    AST_RESET_TO_START: assert property ($rose(convert_start_first_group) |-> !$past(adc_reset))
        else $error("start too soon after reset");
    AST_PAIR: assert property (convert_start_first_group == convert_start_second_group)
        else $error("start groups apart");
    AST_PULSE_HIGH: assert property ($rose(convert_start_first_group) |=> convert_start_first_group)
        else $error("start pulse too short");
endmodule

/* bench/simultaneous_adc_conversion_control_bench.sv */
// Bench joining host and converter ends across the pin interface
`timescale 1ns/1ps
module simultaneous_adc_conversion_control_bench;
    localparam int LO [7] = '{138, 315, 642, 1320, 2640, 5320, 10280};
    localparam int HI [7] = '{166, 364, 752, 1560, 3120, 6320, 12600};
    logic       clock = 1'b0;
    logic       sys_rst = 1'b1;
    logic       start_req = 1'b0;
    logic [2:0] ratio = 3'h0;
    logic       ready;
    logic       read_window;
    logic       result_valid;
    logic [2:0] result_ratio;
    int         failures = 0;
    int         checked = 0;
    adc_conv_if conv_pins();
    adc_conv_device #(.CHANNELS(8)) adc_conv_device_inst (.clock(clock), .sys_rst(sys_rst),
        .pins(conv_pins), .result_valid(result_valid), .result_ratio(result_ratio));
    adc_conv_host #(.WAKE_CYCLES(10)) adc_conv_host_inst (.clock(clock), .sys_rst(sys_rst),
        .pins(conv_pins), .start_req(start_req), .ratio(ratio), .ready(ready),
        .read_window(read_window));
    adc_conv_asserts adc_conv_asserts_inst (.clock(clock), .sys_rst(sys_rst),
        .convert_start_first_group(conv_pins.convert_start_first_group),
        .convert_start_second_group(conv_pins.convert_start_second_group),
        .adc_reset(conv_pins.adc_reset),
        .oversample_ratio_select(conv_pins.oversample_ratio_select),
        .busy(conv_pins.busy), .chip_select_n(conv_pins.chip_select_n));
    always #12.5 clock = ~clock;
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        checked++;
        if (seen !== want) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic give_verdict();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // One start with the given ratio; busy length judged against its window
    task automatic conv(input logic [2:0] r);
        int n;
        n = 0;
        ratio = r;
        while (ready !== 1'b1 && n < 2000) begin @(negedge clock); n++; end
        start_req = 1'b1;
        @(negedge clock);
        start_req = 1'b0;
        n = 0;
        while (conv_pins.busy !== 1'b1 && n < 10) begin @(negedge clock); n++; end
        check(16'(n < 2), 16'h0001);
        n = 0;
        while (conv_pins.busy === 1'b1 && n < 13000) begin
            if (n == 5) check(16'(ready), 16'h0000);
            @(negedge clock);
            n++;
        end
        check(16'(n >= LO[r] && n <= HI[r]), 16'h0001);
        check(16'(result_valid), 16'h0001);
        check(16'(result_ratio), 16'(r));
        n = 0;
        while (read_window !== 1'b1 && n < 20) begin @(negedge clock); n++; end
        check(16'(read_window), 16'h0001);
        check(16'(conv_pins.busy), 16'h0000);
    endtask
    // Request held high: the host must still space the starts out
    task automatic back_to_back();
        int n;
        n = 0;
        ratio = 3'h0;
        start_req = 1'b1;
        while (conv_pins.busy !== 1'b1 && n < 2000) begin @(negedge clock); n++; end
        n = 0;
        while (conv_pins.busy === 1'b1 && n < 300) begin @(negedge clock); n++; end
        while (conv_pins.busy !== 1'b1 && n < 900) begin @(negedge clock); n++; end
        start_req = 1'b0;
        check(16'(n >= 200 && n < 900), 16'h0001);
    endtask
    // Reset in mid conversion clears busy and replays the reset pulse
    task automatic reset_mid();
        int n;
        conv(3'h0);
        start_req = 1'b1;
        repeat (40) @(negedge clock);
        check(16'(conv_pins.busy), 16'h0001);
        sys_rst = 1'b1;
        start_req = 1'b0;
        repeat (2) @(negedge clock);
        sys_rst = 1'b0;
        check(16'(conv_pins.busy), 16'h0000);
        n = 0;
        repeat (10) begin @(negedge clock); n += int'(conv_pins.adc_reset === 1'b1); end
        check(16'(n >= 2), 16'h0001);
    endtask
    initial begin
        repeat (20) @(negedge clock);
        sys_rst = 1'b0;
        for (int r = 0; r < 7; r++) conv(3'(r));
        back_to_back();
        reset_mid();
        conv(3'h1);
        give_verdict();
    end
    initial begin
        #(25 * 60000);
        failures++;
        give_verdict();
    end
endmodule

/* core/adc_conv_device.sv */
// Converter end: conversion timing and busy flag
`timescale 1ns/1ps
module adc_conv_device #(
    parameter int CHANNELS = 8
) (
    input  wire logic clock,
    input  wire logic sys_rst,
    adc_conv_if.converter pins,
    output logic      result_valid,
    output logic [2:0] result_ratio
);
    localparam int BASE = (CHANNELS == 4) ? adc_conv_pkg::CYC_CONV_4CH :
                          (CHANNELS == 6) ? adc_conv_pkg::CYC_CONV_6CH :
                          adc_conv_pkg::CYC_CONV_8CH;

    typedef struct packed {
        adc_conv_pkg::conv_state_t      state;
        logic                           a_prev;
        logic [2:0]                     os;
        logic [adc_conv_pkg::CNT_W-1:0] cnt;
        logic                           busy;
        logic                           valid;
    } dev_t;

    dev_t cur_ff;
    dev_t nxt_ff;

    // Conversion length: base plus one step per pass beyond the first
    function automatic logic [adc_conv_pkg::CNT_W-1:0] conv_len(input logic [2:0] os);
        int passes;
        passes = 1 << ((os > adc_conv_pkg::OS_MAX_CODE) ? 0 : os);
        conv_len = adc_conv_pkg::CNT_W'(BASE + (passes - 1) * adc_conv_pkg::CYC_PASS_STEP);
    endfunction

    always_comb begin
        nxt_ff = cur_ff;
        // Both ends share the clock; a synchroniser here would push busy past 40 ns
        nxt_ff.a_prev = pins.convert_start_first_group;
        nxt_ff.valid = 1'b0;
        case (cur_ff.state)
            adc_conv_pkg::CONV_IDLE: begin
                // Sampling starts on the first group edge; the second group pin is not read here
                if (pins.low_power_control_n && pins.convert_start_first_group && !cur_ff.a_prev) begin
                    nxt_ff.state = adc_conv_pkg::CONV_RUN;
                    nxt_ff.busy  = 1'b1;
                    nxt_ff.os    = pins.oversample_ratio_select;
                    nxt_ff.cnt   = conv_len(pins.oversample_ratio_select);
                end
            end
            adc_conv_pkg::CONV_RUN: begin
                // Busy stays high over every pass
                if (cur_ff.cnt <= adc_conv_pkg::CNT_W'(2)) begin
                    nxt_ff.state = adc_conv_pkg::CONV_DONE;
                end else begin
                    nxt_ff.cnt = cur_ff.cnt - adc_conv_pkg::CNT_W'(1);
                end
            end
            adc_conv_pkg::CONV_DONE: begin
                nxt_ff.busy  = 1'b0;
                nxt_ff.valid = 1'b1;
                nxt_ff.state = adc_conv_pkg::CONV_IDLE;
            end
            default: nxt_ff.state = adc_conv_pkg::CONV_IDLE;
        endcase
        if (pins.adc_reset) begin
            nxt_ff.state = adc_conv_pkg::CONV_IDLE;
            nxt_ff.busy  = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    assign pins.busy    = cur_ff.busy;
    assign result_valid = cur_ff.valid;
    assign result_ratio = cur_ff.os;
endmodule

/* core/adc_conv_host.sv */
// Host end: wake, reset, start pulses and read window
`timescale 1ns/1ps
module adc_conv_host #(
    parameter int WAKE_CYCLES = adc_conv_pkg::CYC_WAKE_LOW_POWER_CONTROL_N
) (
    input  wire logic       clock,
    input  wire logic       sys_rst,
    adc_conv_if.host        pins,
    input  wire logic       start_req,
    input  wire logic [2:0] ratio,
    output logic            ready,
    output logic            read_window
);
    typedef struct packed {
        adc_conv_pkg::host_state_t      state;
        logic [adc_conv_pkg::CNT_W-1:0] cnt;
        logic [adc_conv_pkg::CNT_W-1:0] gap;
        logic [1:0]                     bs;
        logic                           cnv;
        logic                           rst;
        logic                           cs_n;
        logic [2:0]                     os;
        logic                           rdy;
        logic                           awake;
    } host_t;

    host_t cur_ff;
    host_t nxt_ff;

    always_comb begin
        nxt_ff = cur_ff;
        nxt_ff.bs = {cur_ff.bs[0], pins.busy};
        if (cur_ff.gap != '0) nxt_ff.gap = cur_ff.gap - adc_conv_pkg::CNT_W'(1);
        if (cur_ff.cnt != '0) nxt_ff.cnt = cur_ff.cnt - adc_conv_pkg::CNT_W'(1);
        nxt_ff.rdy = 1'b0;
        case (cur_ff.state)
            adc_conv_pkg::HOST_RESET: begin
                nxt_ff.rst = 1'b1;
                if (cur_ff.cnt == '0) begin
                    nxt_ff.rst   = 1'b0;
                    nxt_ff.awake = 1'b1;
                    nxt_ff.state = adc_conv_pkg::HOST_WAKE;
                    nxt_ff.cnt   = adc_conv_pkg::CNT_W'(WAKE_CYCLES);
                end
            end
            adc_conv_pkg::HOST_WAKE: if (cur_ff.cnt == '0) nxt_ff.state = adc_conv_pkg::HOST_READY;
            adc_conv_pkg::HOST_READY: begin
                nxt_ff.rdy = cur_ff.gap == '0;
                if (start_req && cur_ff.gap == '0) begin
                    nxt_ff.os    = ratio;
                    nxt_ff.cnv   = 1'b1;
                    nxt_ff.gap   = adc_conv_pkg::CNT_W'(adc_conv_pkg::CYC_CYCLE);
                    nxt_ff.cnt   = adc_conv_pkg::CNT_W'(adc_conv_pkg::CYC_PULSE);
                    nxt_ff.state = adc_conv_pkg::HOST_HIGH;
                end
            end
            adc_conv_pkg::HOST_HIGH: if (cur_ff.cnt == '0 && cur_ff.bs[1]) begin
                nxt_ff.cnv   = 1'b0;
                nxt_ff.state = adc_conv_pkg::HOST_BUSY;
            end
            adc_conv_pkg::HOST_BUSY: if (!cur_ff.bs[1]) begin
                nxt_ff.cs_n  = 1'b0;
                nxt_ff.cnt   = adc_conv_pkg::CNT_W'(adc_conv_pkg::CYC_PULSE);
                nxt_ff.state = adc_conv_pkg::HOST_READ;
            end
            adc_conv_pkg::HOST_READ: if (cur_ff.cnt == '0) begin
                nxt_ff.cs_n  = 1'b1;
                nxt_ff.state = adc_conv_pkg::HOST_READY;
            end
            default: nxt_ff.state = adc_conv_pkg::HOST_READY;
        endcase
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            cur_ff       <= '0;
            cur_ff.cs_n  <= 1'b1;
            cur_ff.cnt   <= adc_conv_pkg::CNT_W'(adc_conv_pkg::CYC_RESET + adc_conv_pkg::CYC_RST_CNV);
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    assign pins.convert_start_first_group  = cur_ff.cnv;
    assign pins.convert_start_second_group = cur_ff.cnv;
    assign pins.low_power_control_n        = cur_ff.awake;
    assign pins.oversample_ratio_select    = cur_ff.os;
    assign pins.adc_reset                  = cur_ff.rst;
    assign pins.chip_select_n              = cur_ff.cs_n;
    assign ready       = cur_ff.rdy;
    assign read_window = ~cur_ff.cs_n;
endmodule

/* shared/adc_conv_if.sv */
// Pins between the converter and its controlling host
`timescale 1ns/1ps
interface adc_conv_if;
    logic       convert_start_first_group;
    logic       convert_start_second_group;
    logic       low_power_control_n;
    logic [2:0] oversample_ratio_select;
    logic       adc_reset;
    logic       busy;
    logic       chip_select_n;

    modport converter (
        input  convert_start_first_group,
        input  convert_start_second_group,
        input  low_power_control_n,
        input  oversample_ratio_select,
        input  adc_reset,
        input  chip_select_n,
        output busy
    );
    modport host (
        output convert_start_first_group,
        output convert_start_second_group,
        output low_power_control_n,
        output oversample_ratio_select,
        output adc_reset,
        output chip_select_n,
        input  busy
    );
endinterface

/* shared/adc_conv_pkg.sv */
// Constants and types shared by the converter end and the controller end
package adc_conv_pkg;
    // ------------------------------------------------------------
    // Clock
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 25000;

    // ------------------------------------------------------------
    // Times in nanoseconds
    // ------------------------------------------------------------
    localparam int T_CONV_OS1_NS  = 4000;
    localparam int T_CONV_6CH_NS  = 3000;
    localparam int T_CONV_4CH_NS  = 2000;
    // Each extra pass adds 4.5 us, which keeps ratio codes 0 to 6 inside their windows with the 8-channel base
    localparam int T_PASS_STEP_NS = 4500;
    localparam int T_CYCLE_NS     = 5000;
    localparam int T_WAKE_LOW_POWER_CONTROL_N_NS = 100000;
    localparam int T_WAKE_INT_NS  = 30000000;
    localparam int T_WAKE_EXT_NS  = 13000000;
    localparam int T_RESET_NS     = 50;
    localparam int T_PULSE_NS     = 25;
    localparam int T_RST_TO_CNV_NS = 25;
    localparam int T_SKEW_NS      = 500000;

    // Least times round up, longest round down
    localparam int CYC_CONV_8CH  = (T_CONV_OS1_NS * 1000) / CLK_PERIOD_PS;
    localparam int CYC_CONV_6CH  = (T_CONV_6CH_NS * 1000) / CLK_PERIOD_PS;
    localparam int CYC_CONV_4CH  = (T_CONV_4CH_NS * 1000) / CLK_PERIOD_PS;
    localparam int CYC_PASS_STEP = (T_PASS_STEP_NS * 1000) / CLK_PERIOD_PS;
    localparam int CYC_CYCLE     = (T_CYCLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CYC_WAKE_LOW_POWER_CONTROL_N = (T_WAKE_LOW_POWER_CONTROL_N_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CYC_RESET     = (T_RESET_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CYC_PULSE     = (T_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CYC_RST_CNV   = (T_RST_TO_CNV_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CYC_SKEW      = (T_SKEW_NS * 1000) / CLK_PERIOD_PS;

    localparam logic [2:0] OS_MAX_CODE = 3'h6;
    localparam int CNT_W = 24;

    typedef enum logic [1:0] {
        CONV_IDLE = 2'b00,
        CONV_RUN  = 2'b01,
        CONV_DONE = 2'b10
    } conv_state_t;

    typedef enum logic [2:0] {
        HOST_RESET = 3'b000,
        HOST_WAKE  = 3'b001,
        HOST_READY = 3'b010,
        HOST_HIGH  = 3'b011,
        HOST_BUSY  = 3'b100,
        HOST_READ  = 3'b101,
        HOST_GAP   = 3'b110
    } host_state_t;
endpackage
